// ---- gbc_regs.vh ----
`ifndef GBC_REGS_VH
`define GBC_REGS_VH
// ************************************************************
// register map
// ************************************************************
`define GBC_ADDR_PARTNER_PAGE  5'h08
`define GBC_ADDR_CONFIG        5'h09
`define GBC_ADDR_ADVERT        5'h05
`define GBC_CONFIG_RESET       16'h0300
`define GBC_CONFIG_WMASK       16'hff80
`define GBC_TEST_HI            15
`define GBC_TEST_LO            13
`define GBC_ROLE_OVR_BIT       12
`define GBC_ROLE_VAL_BIT       11
`define GBC_PORT_TYPE_BIT      10
`define GBC_FD_ADV_BIT         9
`define GBC_HD_ADV_BIT         8
`define GBC_CABLE_TEST_BIT     7
`define GBC_PAGE_MSG_BIT       13
`define GBC_PAGE_TOGGLE_BIT    11
`define GBC_PAGE_RESET         16'h2001
`define GBC_TEST_NORMAL        3'h0
`endif

// ---- gbc_edge.v ----
`timescale 1ns/1ns
// ************************************************************
// falling edge detector, registered pulse out
// ************************************************************
module gbc_edge (
   ref_clk,
   rstn,
   level,
   fall_pulse
);
   input  wire ref_clk;
   input  wire rstn;
   input  wire level;
   output reg  fall_pulse;

   reg         level_q;

   always @(posedge ref_clk) begin
      if (!rstn) begin
         // follows the pin in reset, so release never shows a false drop
         level_q    <= level;
         fall_pulse <= 1'b0;
      end else begin
         level_q    <= level;
         fall_pulse <= level_q & ~level;
      end
   end
endmodule // gbc_edge

// ---- gbc_config_regs.v ----
`timescale 1ns/1ns
`include "gbc_regs.vh"
// Summary of operation
// - test code 0 normal, 1-4 compliance modes
// - codes 5-7: idles, 0001, pulse+63 zeros
// - override bit picks configured role
// - override role value one master, zero slave
// - port type bit feeds role negotiation
// - full duplex advert from bit 9, strapped
// - half duplex advert from bit 8, strapped
// - bit 7 launches cable test on link loss
// - report partner toggle, starts inverse of 5.11
// - eleven-bit partner page payload read-only
// - bit 13 flags message versus unformatted page
module gbc_config_regs (
   ref_clk,
   rstn,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   strap_fd_adv,
   strap_hd_adv,
   local_toggle_5_11,
   page_valid,
   page_is_message,
   page_toggle,
   page_payload,
   link_up,
   auto_role_master,
   test_pattern_sel,
   role_manual,
   role_master,
   multi_port,
   gig_full_duplex_advert,
   gig_half_duplex_advert,
   cable_test_start
);
   input  wire        ref_clk;
   input  wire        rstn;
   input  wire [4:0]  reg_addr;
   input  wire [15:0] reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [15:0] reg_rdata;
   input  wire        strap_fd_adv;
   input  wire        strap_hd_adv;
   input  wire        local_toggle_5_11;
   input  wire        page_valid;
   input  wire        page_is_message;
   input  wire        page_toggle;
   input  wire [10:0] page_payload;
   input  wire        link_up;
   input  wire        auto_role_master;
   output reg  [7:0]  test_pattern_sel;
   output reg         role_manual;
   output reg         role_master;
   output reg         multi_port;
   output reg         gig_full_duplex_advert;
   output reg         gig_half_duplex_advert;
   output reg         cable_test_start;

   // ************************************************************
   // state
   // ************************************************************
   reg  [15:0] gigabit_base_config;
   reg         partner_page_is_message;
   reg         partner_page_toggle;
   reg  [10:0] partner_page_payload;
   reg         strap_pending;
   reg         page_seen;
   wire        link_fall;
   wire [2:0]  test_code;
   reg  [15:0] next_config;
   reg  [15:0] next_rdata;
   reg  [7:0]  next_test_sel;
   reg         next_role_master;
   wire        config_wr;

   // reset image of the received page word, split into its fields below
   localparam [15:0] PAGE_RESET = `GBC_PAGE_RESET;

   assign test_code = gigabit_base_config[`GBC_TEST_HI:`GBC_TEST_LO];
   // only offset 9 is writable; the page word is read-only
   assign config_wr = reg_wr & (reg_addr == `GBC_ADDR_CONFIG);

   // registered fall pulse: the test start lands two clocks after the drop
   gbc_edge u_link_edge (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .level      (link_up),
      .fall_pulse (link_fall)
   );

   // ************************************************************
   // configuration register
   // ************************************************************
   always @* begin
      next_config = gigabit_base_config;
      if (strap_pending) begin
         // straps sampled one clock after reset release, never in reset
         next_config[`GBC_FD_ADV_BIT] = strap_fd_adv;
         next_config[`GBC_HD_ADV_BIT] = strap_hd_adv;
      end
      // a write in the strap cycle wins, so software keeps its own word
      if (config_wr) begin
         next_config = reg_wdata & `GBC_CONFIG_WMASK;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         gigabit_base_config <= `GBC_CONFIG_RESET;
         strap_pending       <= 1'b1;
      end else begin
         gigabit_base_config <= next_config;
         strap_pending       <= 1'b0;
      end
   end

   // ************************************************************
   // received page status
   // ************************************************************
   // page fields hold until the partner sends its next page; before the first, the toggle tracks the inverse of ours
   always @(posedge ref_clk) begin
      if (!rstn) begin
         partner_page_is_message <= PAGE_RESET[`GBC_PAGE_MSG_BIT];
         partner_page_toggle     <= PAGE_RESET[`GBC_PAGE_TOGGLE_BIT];
         partner_page_payload    <= PAGE_RESET[10:0];
         page_seen               <= 1'b0;
      end else if (page_valid) begin
         partner_page_is_message <= page_is_message;
         partner_page_toggle     <= page_toggle;
         partner_page_payload    <= page_payload;
         page_seen               <= 1'b1;
      end else if (!page_seen) begin
         // before any page, expect the inverse of our own toggle
         partner_page_toggle     <= ~local_toggle_5_11;
      end
   end

   // ************************************************************
   // test pattern and role selection
   // ************************************************************
   always @* begin
      // one-hot, so each pattern engine needs a single enable
      case (test_code)
         3'h0:    next_test_sel = 8'h01;  // normal operation
         3'h1:    next_test_sel = 8'h02;  // waveform
         3'h2:    next_test_sel = 8'h04;  // jitter as master
         3'h3:    next_test_sel = 8'h08;  // jitter as slave
         3'h4:    next_test_sel = 8'h10;  // distortion
         3'h5:    next_test_sel = 8'h20;  // scrambled idles
         3'h6:    next_test_sel = 8'h40;  // repeated 0001
         3'h7:    next_test_sel = 8'h80;  // one pulse, 63 zeros
         default: next_test_sel = 8'h01;
      endcase
   end

   always @* begin
      // value bit only counts under override
      if (gigabit_base_config[`GBC_ROLE_OVR_BIT]) begin
         next_role_master = gigabit_base_config[`GBC_ROLE_VAL_BIT];
      end else begin
         next_role_master = auto_role_master;
      end
   end

   // ************************************************************
   // outputs to the link engine
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         test_pattern_sel       <= 8'h01;
         role_manual            <= 1'b0;
         role_master            <= 1'b0;
         multi_port             <= 1'b0;
         gig_full_duplex_advert <= 1'b1;
         gig_half_duplex_advert <= 1'b1;
         cable_test_start       <= 1'b0;
      end else begin
         test_pattern_sel       <= next_test_sel;
         role_manual            <= gigabit_base_config[`GBC_ROLE_OVR_BIT];
         role_master            <= next_role_master;
         multi_port             <= gigabit_base_config[`GBC_PORT_TYPE_BIT];
         gig_full_duplex_advert <= gigabit_base_config[`GBC_FD_ADV_BIT];
         gig_half_duplex_advert <= gigabit_base_config[`GBC_HD_ADV_BIT];
         // one pulse per drop; a link that bounces starts the test again
         cable_test_start       <= link_fall &
                                   gigabit_base_config[`GBC_CABLE_TEST_BIT];
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always @* begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            `GBC_ADDR_CONFIG: next_rdata = gigabit_base_config & `GBC_CONFIG_WMASK;
            `GBC_ADDR_PARTNER_PAGE: begin
               next_rdata = 16'h0000;
               next_rdata[`GBC_PAGE_MSG_BIT]    = partner_page_is_message;
               next_rdata[`GBC_PAGE_TOGGLE_BIT] = partner_page_toggle;
               next_rdata[10:0]                 = partner_page_payload;
            end
            // unmapped addresses read as zero
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // gbc_config_regs

// ---- gbc_chk.sv ----
`timescale 1ns/1ns
module gbc_chk (
   input wire        ref_clk,
   input wire        rstn,
   input wire [4:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire        strap_fd_adv,
   input wire        strap_hd_adv,
   input wire        link_up,
   input wire        auto_role_master,
   input wire [7:0]  test_pattern_sel,
   input wire        role_manual,
   input wire        role_master,
   input wire        multi_port,
   input wire        gig_full_duplex_advert,
   input wire        gig_half_duplex_advert,
   input wire        cable_test_start
);
   wire wr;
   reg  arm;

   assign wr = reg_wr && reg_addr == 5'h09;

   // shadow of config bit 7, which is not a port
   always @(posedge ref_clk) begin
      if (!rstn) begin
         arm <= 1'b0;
      end else if (wr) begin
         arm <= reg_wdata[7];
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence link_drop;
      $fell(link_up);
   endsequence

   sequence drop_armed;
      link_drop ##1 arm;
   endsequence

   test_sel_a: assert property (wr |-> ##2
      test_pattern_sel == 8'h01 << $past(reg_wdata[15:13], 2))
      else $error("test pattern select does not follow the written code");
   role_ovr_a: assert property (wr |-> ##2
      role_manual == $past(reg_wdata[12], 2))
      else $error("manual role flag does not follow the written bit");
   role_val_a: assert property (wr && reg_wdata[12] |-> ##2
      role_master == $past(reg_wdata[11], 2))
      else $error("manual role does not follow the written value");
   role_auto_a: assert property ((!role_manual && $stable(auto_role_master)) [*2]
      |-> role_master == auto_role_master)
      else $error("automatic role not passed through");
   advert_a: assert property (wr |-> ##2
      {multi_port, gig_full_duplex_advert, gig_half_duplex_advert} == $past(reg_wdata[10:8], 2))
      else $error("port type or advert does not follow the written bits");
   strap_load_a: assert property ($rose(rstn) && !reg_wr |-> ##2
      {gig_full_duplex_advert, gig_half_duplex_advert} == $past({strap_fd_adv, strap_hd_adv}, 2))
      else $error("advert not taken from the straps after reset");
   cable_go_a: assert property (drop_armed |-> ##1 cable_test_start)
      else $error("cable test not started after an armed link drop");
   cable_no_a: assert property (cable_test_start |->
      $past(arm) && $past(link_up, 3) && !$past(link_up, 2))
      else $error("cable test started without an armed link drop");
   rsvd_rd_a: assert property (reg_rd && reg_addr == 5'h09 |=>
      reg_rdata[6:0] == 7'h00)
      else $error("reserved config bits read as nonzero");
endmodule // gbc_chk

bind gbc_config_regs gbc_chk i_gbc_chk (
   .ref_clk                (ref_clk),
   .rstn                   (rstn),
   .reg_addr               (reg_addr),
   .reg_wdata              (reg_wdata),
   .reg_wr                 (reg_wr),
   .reg_rd                 (reg_rd),
   .reg_rdata              (reg_rdata),
   .strap_fd_adv           (strap_fd_adv),
   .strap_hd_adv           (strap_hd_adv),
   .link_up                (link_up),
   .auto_role_master       (auto_role_master),
   .test_pattern_sel       (test_pattern_sel),
   .role_manual            (role_manual),
   .role_master            (role_master),
   .multi_port             (multi_port),
   .gig_full_duplex_advert (gig_full_duplex_advert),
   .gig_half_duplex_advert (gig_half_duplex_advert),
   .cable_test_start       (cable_test_start)
);

// ---- gbc_partner.sv ----
`timescale 1ns/1ns
module gbc_partner (
   input  wire        ref_clk,
   output reg         page_valid = 1'b0,
   output reg         page_is_message = 1'b0,
   output reg         page_toggle = 1'b0,
   output reg         link_up = 1'b0,
   output reg         auto_role_master = 1'b1,
   output reg  [10:0] page_payload = 11'h000
);
   // one page per call; the toggle alternates from page to page
   task send(input m, input [10:0] p);
      begin
         @(posedge ref_clk) #1 {page_valid, page_is_message, page_payload} = {1'b1, m, p};
         page_toggle = !page_toggle;
         // payload is not held once the page is taken
         @(posedge ref_clk) #1 {page_valid, page_payload} = {1'b0, ~p};
      end
   endtask
endmodule // gbc_partner

// ---- tb_gbc_config_regs.sv ----
`timescale 1ns/1ns
module tb_gbc_config_regs;
   reg         ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [4:0]  reg_addr = 5'h00;
   reg  [15:0] reg_wdata = 16'h0000, x;
   wire [15:0] reg_rdata;
   wire [10:0] page_payload;
   wire [7:0]  test_pattern_sel;
   wire        page_valid, page_is_message, page_toggle, link_up, auto_role_master;
   wire        role_manual, role_master, multi_port, cable_test_start;
   wire        gig_full_duplex_advert, gig_half_duplex_advert;
   reg         strap_fd_adv = 1'b1, strap_hd_adv = 1'b0, local_toggle_5_11 = 1'b1;
   integer     failures = 0, checks_done = 0, c, n;
   always #4 ref_clk = !ref_clk;
   gbc_partner i_gbc_partner (.*);
   gbc_config_regs i_gbc_config_regs (.*);
   task chk(input [15:0] g, input [15:0] e);
      begin
         checks_done = checks_done + 1;
         if (g !== e) failures = failures + 1;
         if (g !== e) $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // pins as {manual, master, multi, full, half, 3'h0, pattern select}
   task chk_pins(input [15:0] e);
      begin
         chk({role_manual, role_master, multi_port, gig_full_duplex_advert,
              gig_half_duplex_advert, 3'h0, test_pattern_sel}, e);
      end
   endtask
   // one access per call; a read compares against d
   task acc(input w, input [4:0] a, input [15:0] d);
      begin
         @(posedge ref_clk) #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
         @(posedge ref_clk) #1 {reg_wr, reg_rd} = 2'b00;
         @(posedge ref_clk) #1 if (!w) chk(reg_rdata, d);
      end
   endtask
   task results;
      begin
         if (failures == 0 && checks_done > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      acc(1'b0, 5'h09, 16'h0200);
      acc(1'b1, 5'h08, 16'hffff);
      acc(1'b0, 5'h08, 16'h2001);
      acc(1'b0, 5'h1f, 16'h0000);
      for (c = 0; c < 8; c = c + 1) begin
         x = {c[2:0], c[0], c[1], c[2], c[1], c[0], 8'hff};
         acc(1'b1, 5'h09, x);
         acc(1'b0, 5'h09, x & 16'hff80);
         x = {c[0], c[0] ? c[1] : 1'b1, c[2], c[1], c[0], 3'h0, 8'h01 << c[2:0]};
         chk_pins(x);
      end
      // value bit alone must not move the role while the override is off
      acc(1'b1, 5'h09, 16'h0800);
      acc(1'b0, 5'h09, 16'h0800);
      i_gbc_partner.auto_role_master = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk_pins(16'h0001);
      i_gbc_partner.auto_role_master = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 chk_pins(16'h4001);
      i_gbc_partner.send(1'b0, 11'h5a5);
      acc(1'b0, 5'h08, 16'h0da5);
      i_gbc_partner.send(1'b1, 11'h7ff);
      acc(1'b0, 5'h08, 16'h27ff);
      // link loss with the auto test armed, then disarmed
      for (c = 1; c >= 0; c = c - 1) begin
         acc(1'b1, 5'h09, {8'h00, c[0], 7'h00});
         i_gbc_partner.link_up = 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 i_gbc_partner.link_up = 1'b0;
         n = 0;
         repeat (5) @(posedge ref_clk) #1 n = n + cable_test_start;
         chk(n[15:0], {15'h0000, c[0]});
      end
      // second reset with the other strap levels and our toggle low
      @(posedge ref_clk) #1 {rstn, strap_fd_adv, strap_hd_adv, local_toggle_5_11} = 4'b0010;
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      acc(1'b0, 5'h09, 16'h0100);
      acc(1'b0, 5'h08, 16'h2801);
      chk_pins(16'h4801);
      results;
   end
endmodule // tb_gbc_config_regs
